// ---- rtl/gpbde_top.sv ----
// Purpose: Pin logic of ports B, D and E with peripheral sharing
// Assumes: Peripheral controls are on core_clk_i; pin inputs pass two-flop synchronisers
// Notes:   Data latches keep their contents through reset
//
// Notes on behaviour
// - Each port B pin has a read/write data latch untouched by reset.
// - Port B direction one drives the pin, zero makes it an input.
// - Reset clears all port B direction bits.
// - Port B read gives latch for outputs, pin level for inputs.
// - Data writes always load the latch; input reads still show the pin.
// - Converter channel select takes port B or port D bits 0-3 as inputs.
// - Each port D pin has a read/write data latch untouched by reset.
// - Port D direction one drives the pin, zero makes it an input.
// - Reset clears all port D direction bits.
// - Port D read gives latch for outputs, pin level for inputs.
// - Timer 1 edge/level selects give port D bits 4 and 5 to the timer.
// - Serial enable turns port D bits 6 and 7 into transmit and receive.
// - Slow-edge bit makes port D pin 6 or 7 open-drain; direction kept.
// - Pull-up bit connects pin 6 or 7 pull-up regardless of direction.
// - Port E has a two-bit latch, direction from its own bits.
// - Timer 2 edge/level selects give port E bits 0 and 1 to the timer.
// - Port E direction one drives the pin, zero makes it an input.
// - Reset clears both port E direction bits.
// - Port E read gives latch for outputs, pin level for inputs.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module gpbde_top
    import gpbde_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [GPBDE_AW-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Port B pins
    input wire logic [7:0] pb_pin_i,
    output logic [7:0] pb_pin_o,
    output logic [7:0] pb_pin_oe_o,
    // Port D pins
    input wire logic [7:0] pd_pin_i,
    output logic [7:0] pd_pin_o,
    output logic [7:0] pd_pin_oe_o,
    output logic [1:0] pd_pullup_en_o,
    output logic [1:0] pd_slow_edge_o,
    // Port E pins
    input wire logic [1:0] pe_pin_i,
    output logic [1:0] pe_pin_o,
    output logic [1:0] pe_pin_oe_o,
    // Converter
    input wire logic [4:0] converter_channel_select_i,
    output logic [7:0] pb_analog_sel_o,
    output logic [3:0] pd_analog_sel_o,
    // Timer 1 and timer 2 channels
    input wire logic [1:0] timer1_edge_level_select0_i,
    input wire logic [1:0] timer1_edge_level_select1_i,
    input wire logic [1:0] timer2_edge_level_select0_i,
    input wire logic [1:0] timer2_edge_level_select1_i,
    input wire logic [1:0] timer1_channel_out_i,
    input wire logic [1:0] timer1_channel_oe_i,
    input wire logic [1:0] timer2_channel_out_i,
    input wire logic [1:0] timer2_channel_oe_i,
    output logic [1:0] timer1_channel_in_o,
    output logic [1:0] timer2_channel_in_o,
    // Serial interface
    input wire logic serial_if_enable_i,
    input wire logic serial_txd_i,
    output logic serial_rxd_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Output pins read their latch, input pins their synced level
    function automatic logic [7:0] gpbde_mix(
        input logic [7:0] dir,
        input logic [7:0] latch,
        input logic [7:0] pin
    );
        gpbde_mix = (dir & latch) | (~dir & pin);
    endfunction : gpbde_mix

    function automatic logic gpbde_hit(
        input logic [GPBDE_AW-1:0] addr,
        input logic [7:0] ofs
    );
        gpbde_hit = (addr == ofs);
    endfunction : gpbde_hit

    gpbde_state_s st;
    gpbde_state_s next_st;

    logic [1:0] tmr1_own;
    logic [1:0] tmr2_own;
    logic [7:0] pb_adc;
    logic [3:0] pd_adc;
    logic [7:0] pd_out;
    logic [7:0] pd_oe;

    // ------------------------------------------------------------
    // Pin ownership
    // ------------------------------------------------------------
    always_comb begin
        tmr1_own[0] = timer1_edge_level_select0_i != GPBDE_ELS_GPIO;
        tmr1_own[1] = timer1_edge_level_select1_i != GPBDE_ELS_GPIO;
        tmr2_own[0] = timer2_edge_level_select0_i != GPBDE_ELS_GPIO;
        tmr2_own[1] = timer2_edge_level_select1_i != GPBDE_ELS_GPIO;
        pb_adc = '0;
        pd_adc = '0;
        if (converter_channel_select_i <= GPBDE_ADC_B_LAST) begin
            pb_adc[converter_channel_select_i[2:0]] = 1'b1;
        end
        if (converter_channel_select_i >= GPBDE_ADC_D_FIRST &&
            converter_channel_select_i <= GPBDE_ADC_D_LAST) begin
            // Channel 8 is bit 3 down to channel 11 on bit 0
            pd_adc[2'h3 - converter_channel_select_i[1:0]] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Two-flop input synchronisers
        next_st.pb_s1 = pb_pin_i;
        next_st.pb_s2 = st.pb_s1;
        next_st.pd_s1 = pd_pin_i;
        next_st.pd_s2 = st.pd_s1;
        next_st.pe_s1 = pe_pin_i;
        next_st.pe_s2 = st.pe_s1;
        // Writes load at this edge regardless of direction
        if (reg_wr_i) begin
            if (gpbde_hit(reg_addr_i, GPBDE_OFS_PORT_B_DATA)) begin
                next_st.pb_data = reg_wdata_i;
            end
            if (gpbde_hit(reg_addr_i, GPBDE_OFS_PORT_B_DIR)) begin
                next_st.pb_dir = reg_wdata_i;
            end
            if (gpbde_hit(reg_addr_i, GPBDE_OFS_PORT_D_DATA)) begin
                next_st.pd_data = reg_wdata_i;
            end
            if (gpbde_hit(reg_addr_i, GPBDE_OFS_PORT_D_DIR)) begin
                next_st.pd_dir = reg_wdata_i;
            end
            if (gpbde_hit(reg_addr_i, GPBDE_OFS_PORT_D_CTRL)) begin
                next_st.pd_ctrl = reg_wdata_i[3:0];
            end
            if (gpbde_hit(reg_addr_i, GPBDE_OFS_PORT_E_DATA)) begin
                next_st.pe_data = reg_wdata_i[1:0];
            end
            if (gpbde_hit(reg_addr_i, GPBDE_OFS_PORT_E_DIR)) begin
                next_st.pe_dir = reg_wdata_i[1:0];
            end
        end
        // Read data stands only in the cycle after the read strobe
        next_st.rdata = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                GPBDE_OFS_PORT_B_DATA: begin
                    next_st.rdata = gpbde_mix(st.pb_dir, st.pb_data, st.pb_s2);
                end
                GPBDE_OFS_PORT_D_DATA: begin
                    next_st.rdata = gpbde_mix(st.pd_dir, st.pd_data, st.pd_s2);
                end
                GPBDE_OFS_PORT_E_DATA: begin
                    next_st.rdata = gpbde_mix({6'h00, st.pe_dir}, {6'h00, st.pe_data},
                        {6'h00, st.pe_s2}) & GPBDE_PORT_E_MASK;
                end
                GPBDE_OFS_PORT_B_DIR: begin
                    next_st.rdata = st.pb_dir;
                end
                GPBDE_OFS_PORT_D_DIR: begin
                    next_st.rdata = st.pd_dir;
                end
                GPBDE_OFS_PORT_D_CTRL: begin
                    next_st.rdata = {4'h0, st.pd_ctrl} & GPBDE_CTRL_MASK;
                end
                GPBDE_OFS_PORT_E_DIR: begin
                    next_st.rdata = {6'h00, st.pe_dir};
                end
                default: begin
                    next_st.rdata = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Data latches are left out of the reset branch on purpose
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st.pb_dir <= GPBDE_DIR_RST;
            st.pd_dir <= GPBDE_DIR_RST;
            st.pe_dir <= GPBDE_E_DIR_RST;
            st.pd_ctrl <= GPBDE_CTRL_RST[3:0];
            st.pb_s1 <= '0;
            st.pb_s2 <= '0;
            st.pd_s1 <= '0;
            st.pd_s2 <= '0;
            st.pe_s1 <= '0;
            st.pe_s2 <= '0;
            st.rdata <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Port B drive
    // ------------------------------------------------------------
    always_comb begin
        pb_pin_o = st.pb_data;
        pb_pin_oe_o = st.pb_dir & ~pb_adc;
    end

    // ------------------------------------------------------------
    // Port D drive
    // ------------------------------------------------------------
    always_comb begin
        pd_out = st.pd_data;
        pd_oe = st.pd_dir;
        pd_oe[3:0] = st.pd_dir[3:0] & ~pd_adc;
        if (tmr1_own[0]) begin
            pd_out[GPBDE_PD_TMR0] = timer1_channel_out_i[0];
            pd_oe[GPBDE_PD_TMR0] = timer1_channel_oe_i[0];
        end
        if (tmr1_own[1]) begin
            pd_out[GPBDE_PD_TMR1] = timer1_channel_out_i[1];
            pd_oe[GPBDE_PD_TMR1] = timer1_channel_oe_i[1];
        end
        if (serial_if_enable_i) begin
            pd_out[GPBDE_PD_TXD] = serial_txd_i;
            pd_oe[GPBDE_PD_TXD] = 1'b1;
            pd_out[GPBDE_PD_RXD] = 1'b0;
            pd_oe[GPBDE_PD_RXD] = 1'b0;
        end
        // Open-drain: drive low only, release for a one
        if (st.pd_ctrl[GPBDE_SLOW6_BIT]) begin
            pd_oe[GPBDE_PD_TXD] = pd_oe[GPBDE_PD_TXD] & ~pd_out[GPBDE_PD_TXD];
            pd_out[GPBDE_PD_TXD] = 1'b0;
        end
        if (st.pd_ctrl[GPBDE_SLOW7_BIT]) begin
            pd_oe[GPBDE_PD_RXD] = pd_oe[GPBDE_PD_RXD] & ~pd_out[GPBDE_PD_RXD];
            pd_out[GPBDE_PD_RXD] = 1'b0;
        end
        pd_pin_o = pd_out;
        pd_pin_oe_o = pd_oe;
        pd_slow_edge_o = {st.pd_ctrl[GPBDE_SLOW7_BIT], st.pd_ctrl[GPBDE_SLOW6_BIT]};
        pd_pullup_en_o = {st.pd_ctrl[GPBDE_PU7_BIT], st.pd_ctrl[GPBDE_PU6_BIT]};
    end

    // ------------------------------------------------------------
    // Port E drive
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < 2; i++) begin : g_pe
            always_comb begin
                if (tmr2_own[i]) begin
                    pe_pin_o[i] = timer2_channel_out_i[i];
                    pe_pin_oe_o[i] = timer2_channel_oe_i[i];
                end else begin
                    pe_pin_o[i] = st.pe_data[i];
                    pe_pin_oe_o[i] = st.pe_dir[i];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Peripheral inputs and read data
    // ------------------------------------------------------------
    always_comb begin
        reg_rdata_o = st.rdata;
        pb_analog_sel_o = pb_adc;
        pd_analog_sel_o = pd_adc;
        timer1_channel_in_o = st.pd_s2[GPBDE_PD_TMR1:GPBDE_PD_TMR0];
        timer2_channel_in_o = st.pe_s2;
        serial_rxd_o = st.pd_s2[GPBDE_PD_RXD];
    end

endmodule : gpbde_top
`default_nettype wire

// ---- rtl/gpbde_pkg.sv ----
// Purpose: Constants for the port B, D and E pin logic
// Assumes: Byte-wide register port, one clock
// Notes:   Offsets are byte addresses on the register port
package gpbde_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned GPBDE_AW = 8;
    localparam logic [7:0] GPBDE_OFS_PORT_B_DATA = 8'h01;
    localparam logic [7:0] GPBDE_OFS_PORT_D_DATA = 8'h03;
    localparam logic [7:0] GPBDE_OFS_PORT_B_DIR = 8'h05;
    localparam logic [7:0] GPBDE_OFS_PORT_D_DIR = 8'h07;
    localparam logic [7:0] GPBDE_OFS_PORT_E_DATA = 8'h08;
    localparam logic [7:0] GPBDE_OFS_PORT_D_CTRL = 8'h0A;
    localparam logic [7:0] GPBDE_OFS_PORT_E_DIR = 8'h0C;
    // ------------------------------------------------------------
    // Port D pin control fields
    // ------------------------------------------------------------
    localparam int unsigned GPBDE_SLOW6_BIT = 0;
    localparam int unsigned GPBDE_SLOW7_BIT = 1;
    localparam int unsigned GPBDE_PU6_BIT = 2;
    localparam int unsigned GPBDE_PU7_BIT = 3;
    localparam logic [7:0] GPBDE_CTRL_MASK = 8'h0F;
    localparam logic [7:0] GPBDE_PORT_E_MASK = 8'h03;
    // ------------------------------------------------------------
    // Reset values and converter channels
    // ------------------------------------------------------------
    localparam logic [7:0] GPBDE_DIR_RST = 8'h00;
    localparam logic [7:0] GPBDE_CTRL_RST = 8'h00;
    localparam logic [1:0] GPBDE_E_DIR_RST = 2'h0;
    localparam logic [4:0] GPBDE_ADC_B_LAST = 5'h07;
    localparam logic [4:0] GPBDE_ADC_D_FIRST = 5'h08;
    localparam logic [4:0] GPBDE_ADC_D_LAST = 5'h0B;
    localparam logic [1:0] GPBDE_ELS_GPIO = 2'h0;
    localparam int unsigned GPBDE_PD_TMR0 = 4;
    localparam int unsigned GPBDE_PD_TMR1 = 5;
    localparam int unsigned GPBDE_PD_TXD = 6;
    localparam int unsigned GPBDE_PD_RXD = 7;

    typedef struct packed {
        logic [7:0] pb_data;
        logic [7:0] pb_dir;
        logic [7:0] pd_data;
        logic [7:0] pd_dir;
        logic [3:0] pd_ctrl;
        logic [1:0] pe_data;
        logic [1:0] pe_dir;
        logic [7:0] pb_s1;
        logic [7:0] pb_s2;
        logic [7:0] pd_s1;
        logic [7:0] pd_s2;
        logic [1:0] pe_s1;
        logic [1:0] pe_s2;
        logic [7:0] rdata;
    } gpbde_state_s;
endpackage : gpbde_pkg

// ---- test/gpbde_top_assertions.sv ----
// Purpose: Port checks for the port B, D and E pin logic
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound into gpbde_top
`timescale 1ns/1ps
`default_nettype none
module gpbde_top_assertions (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [7:0] pb_pin_oe_o,
    input wire logic [7:0] pd_pin_i,
    input wire logic [7:0] pd_pin_o,
    input wire logic [7:0] pd_pin_oe_o,
    input wire logic [1:0] pd_slow_edge_o,
    input wire logic [4:0] converter_channel_select_i,
    input wire logic [1:0] timer1_channel_in_o,
    input wire logic serial_if_enable_i,
    input wire logic serial_txd_i,
    input wire logic serial_rxd_o
);
    // --------
    // Checks
    // --------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside read slot");
    a_analog_b_off: assert property (converter_channel_select_i < 5'h08 |->
        !pb_pin_oe_o[converter_channel_select_i[2:0]]) else $error("analog pin driven");
    a_analog_d_off: assert property (converter_channel_select_i inside {[5'h08:5'h0B]} |->
        !pd_pin_oe_o[2'h3 - converter_channel_select_i[1:0]]) else $error("analog pin driven");
    a_serial_tx: assert property (serial_if_enable_i && !pd_slow_edge_o[0] |->
        pd_pin_oe_o[7:6] == 2'b01 && pd_pin_o[6] == serial_txd_i) else $error("serial pins");
    a_open_drain: assert property (pd_slow_edge_o[0] |-> !(pd_pin_oe_o[6] && pd_pin_o[6]))
        else $error("open drain pin driven high");
    a_drain_seven_low: assert property (pd_slow_edge_o[1] |->
        !(pd_pin_oe_o[7] && pd_pin_o[7])) else $error("open drain pin seven driven high");
    a_sync_timer: assert property ($past(rstn_i) && $past(rstn_i, 2) |->
        timer1_channel_in_o == $past(pd_pin_i[5:4], 2)) else $error("timer input sync");
    a_sync_rx: assert property ($past(rstn_i) && $past(rstn_i, 2) |->
        serial_rxd_o == $past(pd_pin_i[7], 2)) else $error("receive input sync");
    a_dir_reset: assert property ($rose(rstn_i) |->
        pb_pin_oe_o == 8'h00 && pd_pin_oe_o[3:0] == 4'h0) else $error("driver on after reset");
endmodule : gpbde_top_assertions
bind gpbde_top gpbde_top_assertions u_chk (
    .core_clk_i, .rstn_i, .reg_rd_i, .reg_rdata_o, .pb_pin_oe_o, .pd_pin_i, .pd_pin_o,
    .pd_pin_oe_o, .pd_slow_edge_o, .converter_channel_select_i, .timer1_channel_in_o,
    .serial_if_enable_i, .serial_txd_i, .serial_rxd_o
);
`default_nettype wire

// ---- test/gpbde_pins.sv ----
// Purpose: Wire levels of the port B, D and E pins
// Assumes: Outside drivers give a level on every undriven pin
// Notes:   Pull-ups win over outside levels on port D pins 6 and 7
`timescale 1ns/1ps
`default_nettype none
module gpbde_pins (
    input wire logic [7:0] pb_o_i,
    input wire logic [7:0] pb_oe_i,
    input wire logic [7:0] pb_ext_i,
    input wire logic [7:0] pd_o_i,
    input wire logic [7:0] pd_oe_i,
    input wire logic [7:0] pd_ext_i,
    input wire logic [1:0] pd_pu_i,
    input wire logic [1:0] pe_o_i,
    input wire logic [1:0] pe_oe_i,
    input wire logic [1:0] pe_ext_i,
    output logic [7:0] pb_lvl_o,
    output logic [7:0] pd_lvl_o,
    output logic [1:0] pe_lvl_o
);
    // --------
    // Levels
    // --------
    always_comb begin
        pb_lvl_o = (pb_oe_i & pb_o_i) | (~pb_oe_i & pb_ext_i);
        pd_lvl_o = (pd_oe_i & pd_o_i) | (~pd_oe_i & (pd_ext_i | {pd_pu_i, 6'h00}));
        pe_lvl_o = (pe_oe_i & pe_o_i) | (~pe_oe_i & pe_ext_i);
    end
endmodule : gpbde_pins
`default_nettype wire

// ---- test/gpbde_top_test.sv ----
// Purpose: Register and pin tests for the port B, D and E logic
// Assumes: gpbde_pins closes the pin loop
// Notes:   Peripheral controls are driven directly
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: %h vs %h", $time, (g), (e)); end end
module gpbde_top_test
    import gpbde_pkg::*;
();
    // --------
    // Signals
    // --------
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ser_en = 1'b0;
    logic txd = 1'b0;
    logic rxd;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic [7:0] pb_ext = 8'hC3;
    logic [7:0] pd_ext = 8'h3C;
    logic [1:0] pe_ext = 2'h2;
    logic [4:0] adc = 5'h1F;
    logic [1:0] els [4] = '{default: 2'h0};
    logic [1:0] t1_out = 2'h0;
    logic [1:0] t1_oe = 2'h0;
    logic [1:0] t2_out = 2'h0;
    logic [1:0] t2_oe = 2'h0;
    logic [7:0] rdat, pb_i, pb_o, pb_oe, pd_i, pd_o, pd_oe, pb_an, eb;
    logic [3:0] pd_an, ed;
    logic [1:0] pu, slow, pe_i, pe_o, pe_oe, t1_in, t2_in;
    logic [7:0] ofs_d [3] = '{GPBDE_OFS_PORT_B_DATA, GPBDE_OFS_PORT_D_DATA, GPBDE_OFS_PORT_E_DATA};
    logic [7:0] ofs_r [3] = '{GPBDE_OFS_PORT_B_DIR, GPBDE_OFS_PORT_D_DIR, GPBDE_OFS_PORT_E_DIR};
    logic [7:0] msk [3] = '{8'hFF, 8'hFF, 8'h03};
    logic [7:0] xv [3] = '{8'hC3, 8'h3C, 8'h02};
    int bad_count = 0;
    int cmp_count = 0;
    always #5 core_clk_i = ~core_clk_i;
    gpbde_top u_dut (
        .core_clk_i, .rstn_i, .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdat), .pb_pin_i(pb_i), .pb_pin_o(pb_o), .pb_pin_oe_o(pb_oe),
        .pd_pin_i(pd_i), .pd_pin_o(pd_o), .pd_pin_oe_o(pd_oe), .pd_pullup_en_o(pu),
        .pd_slow_edge_o(slow), .pe_pin_i(pe_i), .pe_pin_o(pe_o), .pe_pin_oe_o(pe_oe),
        .converter_channel_select_i(adc), .pb_analog_sel_o(pb_an), .pd_analog_sel_o(pd_an),
        .timer1_edge_level_select0_i(els[0]), .timer1_edge_level_select1_i(els[1]),
        .timer2_edge_level_select0_i(els[2]), .timer2_edge_level_select1_i(els[3]),
        .timer1_channel_out_i(t1_out), .timer1_channel_oe_i(t1_oe), .timer2_channel_out_i(t2_out),
        .timer2_channel_oe_i(t2_oe), .timer1_channel_in_o(t1_in), .timer2_channel_in_o(t2_in),
        .serial_if_enable_i(ser_en), .serial_txd_i(txd), .serial_rxd_o(rxd)
    );
    gpbde_pins u_pins (
        .pb_o_i(pb_o), .pb_oe_i(pb_oe), .pb_ext_i(pb_ext), .pd_o_i(pd_o), .pd_oe_i(pd_oe),
        .pd_ext_i(pd_ext), .pd_pu_i(pu), .pe_o_i(pe_o), .pe_oe_i(pe_oe), .pe_ext_i(pe_ext),
        .pb_lvl_o(pb_i), .pd_lvl_o(pd_i), .pe_lvl_o(pe_i)
    );
    // --------
    // Tasks
    // --------
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
        input logic [7:0] e);
        wr <= w;
        rd <= r;
        addr <= a;
        wdat <= d;
        @(posedge core_clk_i);
        #1;
        if (r) `CHK(rdat, e)
    endtask : bus
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d, 8'h00);
    endtask : wrr
    task automatic rdr(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, 1'b1, a, 8'h00, e);
    endtask : rdr
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
    endtask : idle
    task automatic wrap_up();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    // --------
    // Sequence
    // --------
    initial begin
        repeat (20000) @(posedge core_clk_i);
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge core_clk_i);
        #1;
        rstn_i <= 1'b1;
        for (int i = 0; i < 3; i++) rdr(ofs_r[i], 8'h00);
        rdr(GPBDE_OFS_PORT_D_CTRL, 8'h00);
        `CHK({pb_oe, pd_oe, pe_oe}, 18'h0)
        for (int i = 0; i < 3; i++) wrr(ofs_d[i], 8'h5A);
        rstn_i <= 1'b0;
        idle(2);
        rstn_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wrr(ofs_r[i], 8'hFF);
            rdr(ofs_d[i], 8'h5A & msk[i]);
        end
        `CHK({pb_o, pb_oe, pd_oe, pe_oe}, {8'h5A, 8'hFF, 8'hFF, 2'h3})
        for (int i = 0; i < 3; i++) begin
            wrr(ofs_d[i], 8'h96);
            wrr(ofs_r[i], 8'h05);
            idle(2);
            rdr(ofs_d[i], (8'h96 & 8'h05 | xv[i] & 8'hFA) & msk[i]);
            rdr(ofs_r[i], 8'h05 & msk[i]);
        end
        wrr(8'h20, 8'hFF);
        rdr(8'h20, 8'h00);
        wrr(GPBDE_OFS_PORT_B_DIR, 8'hFF);
        wrr(GPBDE_OFS_PORT_D_DIR, 8'hFF);
        for (int s = 0; s < 13; s++) begin
            adc <= 5'(s);
            idle(1);
            eb = (s < 8) ? 8'h01 << s : 8'h00;
            ed = (s >= 8 && s < 12) ? 4'h8 >> (s - 8) : 4'h0;
            `CHK({pb_an, pd_an, pb_oe, pd_oe[3:0]}, {eb, ed, ~eb, ~ed})
        end
        adc <= 5'h1F;
        rdr(GPBDE_OFS_PORT_B_DIR, 8'hFF);
        t1_oe <= 2'b01;
        t2_oe <= 2'b10;
        for (int c = 1; c < 4; c++) begin
            foreach (els[k]) els[k] <= 2'(c);
            t1_out <= 2'(c);
            t2_out <= 2'(c);
            pd_ext[5] <= c[1];
            pe_ext[0] <= c[0];
            idle(2);
            `CHK({pd_oe[5:4], pd_o[4], pe_oe, pe_o[1]}, {2'b01, c[0], 2'b10, c[1]})
            `CHK({t1_in, t2_in}, {2'(c), 2'(c)})
        end
        t1_oe <= 2'b10;
        t2_oe <= 2'b01;
        t1_out <= 2'b10;
        t2_out <= 2'b01;
        idle(1);
        `CHK({pd_oe[5:4], pd_o[5], pe_oe, pe_o[0]}, {2'b10, 1'b1, 2'b01, 1'b1})
        foreach (els[k]) els[k] <= 2'h0;
        idle(1);
        `CHK({pd_oe, pe_oe}, 10'h3FD)
        ser_en <= 1'b1;
        for (int b = 0; b < 2; b++) begin
            txd <= b[0];
            pd_ext[7] <= ~b[0];
            idle(2);
            `CHK({pd_oe[7:6], pd_o[6], rxd}, {2'b01, b[0], ~b[0]})
        end
        ser_en <= 1'b0;
        wrr(GPBDE_OFS_PORT_D_CTRL, 8'hFF);
        rdr(GPBDE_OFS_PORT_D_CTRL, 8'h0F);
        `CHK({slow, pu, pd_oe[7:6], pd_o[6]}, 7'b1111010)
        wrr(GPBDE_OFS_PORT_D_DIR, 8'h3F);
        idle(2);
        rdr(GPBDE_OFS_PORT_D_DATA, 8'hD6);
        rdr(GPBDE_OFS_PORT_D_DIR, 8'h3F);
        wrap_up();
    end
endmodule : gpbde_top_test
`default_nettype wire
